/* File: rca_pkg.sv */
// rca_pkg: constants and types for the core datapath.
// assumes one core clock; pcl, status, fsr and pclath are software-visible registers.
package rca_pkg;
    localparam int DATA_W       = 8;
    localparam int INSTR_W      = 14;
    localparam int PC_W         = 11;
    localparam int ADDR_W       = 7;
    localparam int GPR_DEPTH    = 128;
    localparam int STACK_DEPTH  = 8;
    localparam int STACK_PTR_W  = 3;
    // instruction field positions
    localparam int OP_HI        = 13;
    localparam int OP_LO        = 8;
    localparam int DEST_BIT     = 7;
    // status bit positions
    localparam int ST_CARRY     = 0;
    localparam int ST_NIBBLE    = 1;
    localparam int ST_ZERO      = 2;
    // special function addresses inside the data space
    localparam logic [6:0] SFR_INDIRECT = 7'h00;
    localparam logic [6:0] SFR_PCL      = 7'h02;
    localparam logic [6:0] SFR_STATUS   = 7'h03;
    localparam logic [6:0] SFR_FSR      = 7'h04;
    localparam logic [6:0] SFR_PCLATH   = 7'h0A;
    localparam logic [6:0] GPR_BASE     = 7'h20;
    // reset values
    localparam logic [7:0]  ACC_RST    = 8'h00;
    localparam logic [7:0]  STATUS_RST = 8'h18;
    localparam logic [10:0] PC_RST     = 11'h000;
    localparam logic [13:0] NOP_WORD   = 14'h0000;

    typedef enum logic [3:0] {
        RCA_OP_PASS_F,
        RCA_OP_PASS_K,
        RCA_OP_ADD,
        RCA_OP_SUB,
        RCA_OP_AND,
        RCA_OP_IOR,
        RCA_OP_XOR,
        RCA_OP_COM,
        RCA_OP_INC,
        RCA_OP_DEC,
        RCA_OP_RLF,
        RCA_OP_RRF,
        RCA_OP_SWAP,
        RCA_OP_CLR
    } rca_alu_e;

    typedef enum logic [1:0] {
        RCA_ST_RESET,
        RCA_ST_RUN,
        RCA_ST_FLUSH
    } rca_pipe_e;
endpackage : rca_pkg

/* File: rca_gpr_mem.sv */
// rca_gpr_mem: general purpose file registers, registered read port.
// assumes one clock; read address presented one cycle before use.
`timescale 1ns/10ps
module rca_gpr_mem
    import rca_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       clk_en,
    input  wire logic [rca_pkg::ADDR_W-1:0] rd_addr,
    output logic      [rca_pkg::DATA_W-1:0] rd_data,
    input  wire logic                       wr_en,
    input  wire logic [rca_pkg::ADDR_W-1:0] wr_addr,
    input  wire logic [rca_pkg::DATA_W-1:0] wr_data
);
    logic [DATA_W-1:0] mem [GPR_DEPTH];
    // a word written on this edge is passed on, so no stale read
    wire logic         fwd_hit = wr_en && (wr_addr == rd_addr);

    // no reset: contents undefined after power-up, as in the real array
    always_ff @(posedge clk)
    begin
        if (clk_en)
        begin
            if (wr_en)
            begin
                mem[wr_addr] <= wr_data;
            end
            rd_data <= fwd_hit ? wr_data : mem[rd_addr];
        end
    end
endmodule : rca_gpr_mem

/* File: rca_core.sv */
// rca_core: 8-bit alu datapath with fetch/execute pipeline.
// assumes program memory answers within the same cycle (comb read).
`timescale 1ns/10ps
module rca_core
    import rca_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        clk_en,
    output logic      [rca_pkg::PC_W-1:0]    prog_addr,
    input  wire logic [rca_pkg::INSTR_W-1:0] prog_data,
    output logic      [rca_pkg::DATA_W-1:0]  acc_out,
    output logic      [rca_pkg::DATA_W-1:0]  status_out,
    output logic                             branch_taken
);
    import rca_pkg::*;

    // instruction encodings kept local to the decoder
    localparam logic [5:0] OPC_MOVWF  = 6'h00;
    localparam logic [5:0] OPC_SUBWF  = 6'h02;
    localparam logic [5:0] OPC_DECF   = 6'h03;
    localparam logic [5:0] OPC_IORWF  = 6'h04;
    localparam logic [5:0] OPC_ANDWF  = 6'h05;
    localparam logic [5:0] OPC_XORWF  = 6'h06;
    localparam logic [5:0] OPC_ADDWF  = 6'h07;
    localparam logic [5:0] OPC_MOVF   = 6'h08;
    localparam logic [5:0] OPC_COMF   = 6'h09;
    localparam logic [5:0] OPC_INCF   = 6'h0A;
    localparam logic [5:0] OPC_RRF    = 6'h0C;
    localparam logic [5:0] OPC_RLF    = 6'h0D;
    localparam logic [5:0] OPC_SWAPF  = 6'h0E;
    localparam logic [5:0] OPC_CLRF   = 6'h01;
    localparam logic [5:0] OPC_MOVLW  = 6'h30;
    localparam logic [5:0] OPC_RETLW  = 6'h34;
    localparam logic [5:0] OPC_IORLW  = 6'h38;
    localparam logic [5:0] OPC_ANDLW  = 6'h39;
    localparam logic [5:0] OPC_XORLW  = 6'h3A;
    localparam logic [5:0] OPC_SUBLW  = 6'h3C;
    localparam logic [5:0] OPC_ADDLW  = 6'h3E;
    localparam logic [2:0] GRP_CALL   = 3'b100;
    localparam logic [2:0] GRP_GOTO   = 3'b101;
    localparam logic [13:0] WORD_RET  = 14'h0008;

    // decoded operation for a six-bit opcode
    function automatic rca_alu_e alu_op_of(input logic [5:0] opc);
        rca_alu_e r;
        r = RCA_OP_PASS_F;
        case (opc)
            OPC_ADDWF, OPC_ADDLW: r = RCA_OP_ADD;
            OPC_SUBWF, OPC_SUBLW: r = RCA_OP_SUB;
            OPC_ANDWF, OPC_ANDLW: r = RCA_OP_AND;
            OPC_IORWF, OPC_IORLW: r = RCA_OP_IOR;
            OPC_XORWF, OPC_XORLW: r = RCA_OP_XOR;
            OPC_COMF:             r = RCA_OP_COM;
            OPC_INCF:             r = RCA_OP_INC;
            OPC_DECF:             r = RCA_OP_DEC;
            OPC_RLF:              r = RCA_OP_RLF;
            OPC_RRF:              r = RCA_OP_RRF;
            OPC_SWAPF:            r = RCA_OP_SWAP;
            OPC_CLRF:             r = RCA_OP_CLR;
            OPC_MOVLW, OPC_RETLW: r = RCA_OP_PASS_K;
            OPC_MOVWF:            r = RCA_OP_PASS_K;
            default:              r = RCA_OP_PASS_F;
        endcase
        return r;
    endfunction : alu_op_of

    // literal-operand instructions use the immediate field
    function automatic logic is_literal(input logic [5:0] opc);
        return opc[5:4] == 2'b11;
    endfunction : is_literal

    rca_pipe_e                state_reg;
    rca_pipe_e                state_next;
    logic [PC_W-1:0]          pc_reg;
    logic [PC_W-1:0]          pc_next;
    logic [INSTR_W-1:0]       ir_reg;
    logic [DATA_W-1:0]        acc_reg;
    logic [DATA_W-1:0]        status_reg;
    logic [DATA_W-1:0]        fsr_reg;
    logic [DATA_W-1:0]        pclath_reg;
    logic [PC_W-1:0]          stack_mem [STACK_DEPTH];
    logic [STACK_PTR_W-1:0]   sp_reg;

    // decode
    wire logic [5:0]          opc       = ir_reg[OP_HI:OP_LO];
    wire logic [2:0]          grp       = ir_reg[13:11];
    wire logic                dest_file = ir_reg[DEST_BIT];
    wire logic [DATA_W-1:0]   lit       = ir_reg[7:0];
    wire logic [ADDR_W-1:0]   f_dir     = ir_reg[6:0];
    wire logic                exec_ok   = state_reg == RCA_ST_RUN;
    wire logic                is_call   = exec_ok && grp == GRP_CALL;
    wire logic                is_goto   = exec_ok && grp == GRP_GOTO;
    wire logic                is_ret    = exec_ok && ir_reg == WORD_RET;
    wire logic                is_retlw  = exec_ok && opc == OPC_RETLW;
    wire rca_alu_e            op        = alu_op_of(opc);
    wire logic                use_lit   = is_literal(opc);
    wire logic                byte_op   = opc[5:4] == 2'b00;

    // indirect through the pointer when address zero is named
    wire logic [ADDR_W-1:0]   f_addr    = (f_dir == SFR_INDIRECT)
                                          ? fsr_reg[ADDR_W-1:0] : f_dir;
    wire logic                f_is_gpr  = f_addr >= GPR_BASE;
    logic      [DATA_W-1:0]   gpr_rdata;
    logic      [DATA_W-1:0]   f_val;

    // sfr read mux; pc and status visible as file registers
    always_comb
    begin
        case (f_addr)
            SFR_PCL:    f_val = pc_reg[7:0];
            SFR_STATUS: f_val = status_reg;
            SFR_FSR:    f_val = fsr_reg;
            SFR_PCLATH: f_val = pclath_reg;
            default:    f_val = f_is_gpr ? gpr_rdata : 8'h00;
        endcase
    end

    // operand selection
    wire logic [DATA_W-1:0]   opnd_b  = use_lit ? lit : f_val;
    wire logic [DATA_W-1:0]   opnd_a  = acc_reg;

    // adder shared by add and subtract; subtract adds the complement + 1
    wire logic                sub_mode = op == RCA_OP_SUB;
    wire logic [DATA_W-1:0]   add_x    = sub_mode ? ~opnd_a : opnd_a;
    wire logic [4:0]          lo_sum   = {1'b0, opnd_b[3:0]}
                                         + {1'b0, add_x[3:0]}
                                         + {4'h0, sub_mode};
    wire logic [4:0]          hi_sum   = {1'b0, opnd_b[7:4]}
                                         + {1'b0, add_x[7:4]}
                                         + {4'h0, lo_sum[4]};
    wire logic [DATA_W-1:0]   sum      = {hi_sum[3:0], lo_sum[3:0]};
    wire logic                c_in     = status_reg[ST_CARRY];

    logic [DATA_W-1:0]        result;
    logic                     upd_c;
    logic                     upd_nf;
    logic                     upd_z;
    logic                     new_c;

    always_comb
    begin
        result = opnd_b;
        upd_c  = 1'b0;
        upd_nf = 1'b0;
        upd_z  = 1'b0;
        new_c  = c_in;
        case (op)
            RCA_OP_ADD, RCA_OP_SUB:
            begin
                // carry out is 1 when no borrow occurs
                result = sum;
                upd_c  = 1'b1;
                upd_nf = 1'b1;
                upd_z  = 1'b1;
                new_c  = hi_sum[4];
            end
            RCA_OP_AND:  begin result = opnd_a & opnd_b; upd_z = 1'b1; end
            RCA_OP_IOR:  begin result = opnd_a | opnd_b; upd_z = 1'b1; end
            RCA_OP_XOR:  begin result = opnd_a ^ opnd_b; upd_z = 1'b1; end
            RCA_OP_COM:  begin result = ~opnd_b; upd_z = 1'b1; end
            RCA_OP_INC:  begin result = opnd_b + 8'h01; upd_z = 1'b1; end
            RCA_OP_DEC:  begin result = opnd_b - 8'h01; upd_z = 1'b1; end
            RCA_OP_RLF:
            begin
                result = {opnd_b[6:0], c_in};
                upd_c  = 1'b1;
                new_c  = opnd_b[7];
            end
            RCA_OP_RRF:
            begin
                result = {c_in, opnd_b[7:1]};
                upd_c  = 1'b1;
                new_c  = opnd_b[0];
            end
            RCA_OP_SWAP: result = {opnd_b[3:0], opnd_b[7:4]};
            RCA_OP_CLR:  begin result = 8'h00; upd_z = 1'b1; end
            RCA_OP_PASS_K: result = (opc == OPC_MOVWF) ? acc_reg : opnd_b;
            RCA_OP_PASS_F: begin result = opnd_b; upd_z = byte_op; end
            default:     result = opnd_b;
        endcase
    end

    wire logic                res_zero = result == 8'h00;
    wire logic [DATA_W-1:0]   status_new;
    assign status_new[ST_CARRY]  = upd_c  ? new_c : status_reg[ST_CARRY];
    assign status_new[ST_NIBBLE] = upd_nf ? lo_sum[4]
                                          : status_reg[ST_NIBBLE];
    assign status_new[ST_ZERO]   = upd_z  ? res_zero
                                          : status_reg[ST_ZERO];
    assign status_new[7:3]       = status_reg[7:3];

    // where the result goes
    wire logic                alu_instr = exec_ok && (byte_op || use_lit)
                                          && !is_retlw;
    // clear with destination bit low empties the accumulator
    wire logic                to_file   = alu_instr && byte_op
                                          && dest_file;
    wire logic                to_acc    = (alu_instr && !to_file
                                          && opc != OPC_MOVWF) || is_retlw;
    wire logic                gpr_we    = to_file && f_is_gpr;
    wire logic                pcl_we    = to_file && f_addr == SFR_PCL;

    // program flow
    wire logic [PC_W-1:0]     pc_inc    = pc_reg + 11'h001;
    wire logic [PC_W-1:0]     jump_tgt  = ir_reg[10:0];
    wire logic                take      = is_call || is_goto || is_ret
                                          || is_retlw || pcl_we;
    always_comb
    begin
        pc_next = pc_inc;
        if (is_call || is_goto)
            pc_next = jump_tgt;
        else if (is_ret || is_retlw)
            pc_next = stack_mem[sp_reg - 3'h1];
        else if (pcl_we)
            pc_next = {pclath_reg[2:0], result};
    end

    // pipeline: flush replaces the prefetched word with a bubble
    always_comb
    begin
        case (state_reg)
            RCA_ST_RESET: state_next = RCA_ST_RUN;
            RCA_ST_RUN:   state_next = take ? RCA_ST_FLUSH
                                            : RCA_ST_RUN;
            RCA_ST_FLUSH: state_next = RCA_ST_RUN;
            default:      state_next = RCA_ST_RESET;
        endcase
    end

    assign prog_addr    = pc_reg;
    assign acc_out      = acc_reg;
    assign status_out   = status_reg;
    assign branch_taken = take;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= RCA_ST_RESET;
            pc_reg    <= PC_RST;
            ir_reg    <= NOP_WORD;
            sp_reg    <= 3'h0;
        end
        else if (clk_en)
        begin
            state_reg <= state_next;
            pc_reg    <= pc_next;
            // next word fetched while current executes
            ir_reg    <= take ? NOP_WORD : prog_data;
            if (is_call)
                sp_reg <= sp_reg + 3'h1;
            else if (is_ret || is_retlw)
                sp_reg <= sp_reg - 3'h1;
        end
    end

    // stack wraps silently when overrun, like the classic core
    always_ff @(posedge clk)
    begin
        if (clk_en && is_call)
            stack_mem[sp_reg] <= pc_reg;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            acc_reg    <= ACC_RST;
            status_reg <= STATUS_RST;
            fsr_reg    <= 8'h00;
            pclath_reg <= 8'h00;
        end
        else if (clk_en)
        begin
            if (to_acc)
                acc_reg <= result;
            if (alu_instr)
                status_reg <= status_new;
            if (to_file && f_addr == SFR_STATUS)
                status_reg <= {result[7:3], status_new[2:0]};
            if (to_file && f_addr == SFR_FSR)
                fsr_reg <= result;
            if (to_file && f_addr == SFR_PCLATH)
                pclath_reg <= result;
        end
    end

    // gpr read address comes from the word being fetched
    wire logic [ADDR_W-1:0]   next_f    = prog_data[6:0];
    // pointer written by the word now executing steers this fetch
    wire logic [DATA_W-1:0]   fsr_now   = (to_file && f_addr == SFR_FSR)
                                          ? result : fsr_reg;
    wire logic [ADDR_W-1:0]   next_addr = (next_f == SFR_INDIRECT)
                                          ? fsr_now[ADDR_W-1:0] : next_f;

    rca_gpr_mem u_gpr (
        .clk     (clk),
        .clk_en  (clk_en),
        .rd_addr (next_addr),
        .rd_data (gpr_rdata),
        .wr_en   (gpr_we),
        .wr_addr (f_addr),
        .wr_data (result)
    );
endmodule : rca_core

/* File: rca_core_sva.sv */
// rca_core_sva: port-level timing checks for the core datapath.
// assumes one clock; sync active-low reset applied with clk_en high.
`timescale 1ns/10ps
module rca_core_sva
    import rca_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        clk_en,
    input  wire logic [rca_pkg::PC_W-1:0]    prog_addr,
    input  wire logic [rca_pkg::INSTR_W-1:0] prog_data,
    input  wire logic [rca_pkg::DATA_W-1:0]  acc_out,
    input  wire logic [rca_pkg::DATA_W-1:0]  status_out,
    input  wire logic                        branch_taken
);
    import rca_pkg::*;
    default clocking cb @(posedge clk);
    endclocking

    a_reset_values: assert property (
        (!rst_n && clk_en) |=> (acc_out == ACC_RST
            && status_out == STATUS_RST && prog_addr == PC_RST))
        else $error("reset values wrong");
    a_reset_bubble: assert property (
        (!rst_n && clk_en ##1 rst_n && clk_en)
            |=> (acc_out == ACC_RST && status_out == STATUS_RST))
        else $error("first cycle after reset not a bubble");
    a_reset_quiet: assert property (
        (!rst_n && clk_en) |=> !branch_taken)
        else $error("branch flagged straight after reset");
    a_freeze_hold: assert property (disable iff (!rst_n)
        !clk_en |=> ($stable(acc_out) && $stable(status_out)
            && $stable(prog_addr)))
        else $error("state moved while clock enable low");
    a_freeze_branch: assert property (disable iff (!rst_n)
        !clk_en |=> $stable(branch_taken))
        else $error("branch flag moved while frozen");
    a_pc_step: assert property (disable iff (!rst_n)
        (rst_n && clk_en && !branch_taken)
            |=> (prog_addr - $past(prog_addr)) == 11'h001)
        else $error("fetch address did not step by one");
    a_branch_single: assert property (disable iff (!rst_n)
        (clk_en && branch_taken) |=> !branch_taken)
        else $error("branch not followed by a bubble");
    a_bubble_quiet: assert property (disable iff (!rst_n)
        (clk_en && branch_taken ##1 clk_en)
            |=> ($stable(acc_out) && $stable(status_out)))
        else $error("discarded word changed accumulator or status");

    c_branch: cover property (disable iff (!rst_n) branch_taken);
    c_freeze: cover property (disable iff (!rst_n) !clk_en ##1 !clk_en);
    c_zero: cover property (disable iff (!rst_n) status_out[ST_ZERO]);
endmodule : rca_core_sva

bind rca_core rca_core_sva i_sva (
    .clk          (clk),
    .rst_n        (rst_n),
    .clk_en       (clk_en),
    .prog_addr    (prog_addr),
    .prog_data    (prog_data),
    .acc_out      (acc_out),
    .status_out   (status_out),
    .branch_taken (branch_taken)
);

/* File: rca_prog_rom.sv */
// rca_prog_rom: program memory standing on the core's fetch bus.
// assumes the bench loads words while the core is held in reset.
`timescale 1ns/10ps
module rca_prog_rom
    import rca_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        load_en,
    input  wire logic [rca_pkg::PC_W-1:0]    load_addr,
    input  wire logic [rca_pkg::INSTR_W-1:0] load_word,
    input  wire logic [rca_pkg::PC_W-1:0]    rd_addr,
    output logic      [rca_pkg::INSTR_W-1:0] rd_data
);
    import rca_pkg::*;
    logic [INSTR_W-1:0] rom_reg [0:(1<<PC_W)-1];

    // empty locations read as no-op, like an erased part
    initial for (int i = 0; i < (1 << PC_W); i++) rom_reg[i] = NOP_WORD;
    always @(posedge clk)
        if (load_en) rom_reg[load_addr] <= load_word;
    // same-cycle read, full 14-bit word on its own bus
    assign rd_data = rom_reg[rd_addr];
endmodule : rca_prog_rom

/* File: rca_core_alu_datapath_bench.sv */
// rca_core_alu_datapath_bench: runs small programs through the core.
// assumes program memory model answers combinationally.
`timescale 1ns/10ps
module rca_core_alu_datapath_bench;
    import rca_pkg::*;
    typedef struct packed {
        logic [0:3][13:0] w;
        logic [7:0]       acc;
        logic [2:0]       fl;
    } rca_row_s;
    rca_row_s rows [25] = '{
        '{{14'h300F, 14'h3E01, 14'h0000, 14'h0000}, 8'h10, 3'h2},
        '{{14'h30FF, 14'h3E01, 14'h0000, 14'h0000}, 8'h00, 3'h7},
        '{{14'h3001, 14'h3C03, 14'h0000, 14'h0000}, 8'h02, 3'h3},
        '{{14'h3001, 14'h3C00, 14'h0000, 14'h0000}, 8'hFF, 3'h0},
        '{{14'h3005, 14'h3C05, 14'h0000, 14'h0000}, 8'h00, 3'h7},
        '{{14'h30F0, 14'h390F, 14'h0000, 14'h0000}, 8'h00, 3'h4},
        '{{14'h30F0, 14'h380F, 14'h0000, 14'h0000}, 8'hFF, 3'h0},
        '{{14'h30AA, 14'h3AAA, 14'h0000, 14'h0000}, 8'h00, 3'h4},
        '{{14'h305A, 14'h00A0, 14'h3010, 14'h0720}, 8'h6A, 3'h0},
        '{{14'h303C, 14'h00A1, 14'h0E21, 14'h0000}, 8'hC3, 3'h0},
        '{{14'h303C, 14'h00A1, 14'h0921, 14'h0000}, 8'hC3, 3'h0},
        '{{14'h3081, 14'h00A2, 14'h0D22, 14'h0000}, 8'h02, 3'h1},
        '{{14'h3001, 14'h00A2, 14'h0C22, 14'h0000}, 8'h00, 3'h1},
        '{{14'h3001, 14'h00A3, 14'h0323, 14'h0000}, 8'h00, 3'h4},
        '{{14'h30FF, 14'h00A3, 14'h0A23, 14'h0000}, 8'h00, 3'h4},
        '{{14'h3003, 14'h00A4, 14'h3005, 14'h0224}, 8'hFE, 3'h0},
        '{{14'h3055, 14'h0100, 14'h0000, 14'h0000}, 8'h00, 3'h4},
        '{{14'h30FF, 14'h3E01, 14'h0803, 14'h0000}, 8'h1F, 3'h3},
        '{{14'h0000, 14'h0000, 14'h0802, 14'h0000}, 8'h03, 3'h0},
        '{{14'h303C, 14'h00A5, 14'h300F, 14'h0525}, 8'h0C, 3'h0},
        '{{14'h3030, 14'h00A5, 14'h3003, 14'h0425}, 8'h33, 3'h0},
        '{{14'h3055, 14'h00A5, 14'h0000, 14'h0625}, 8'h00, 3'h4},
        '{{14'h2003, 14'h2801, 14'h0000, 14'h3477}, 8'h77, 3'h0},
        '{{14'h3004, 14'h0084, 14'h3000, 14'h0800}, 8'h04, 3'h0},
        '{{14'h3003, 14'h0082, 14'h30EE, 14'h3066}, 8'h66, 3'h0}
    };
    logic        clk       = 1'b0;
    logic        rst_n     = 1'b0;
    logic        clk_en    = 1'b1;
    logic        load_en   = 1'b0;
    logic [10:0] load_addr = 11'h000;
    logic [13:0] load_word = 14'h0000;
    logic        saw_bad   = 1'b0;
    logic [10:0] prog_addr;
    logic [13:0] prog_data;
    logic [7:0]  acc_out;
    logic [7:0]  status_out;
    logic        branch_taken;
    int          failures   = 0;
    int          num_checks = 0;
    int          n_br       = 0;
    int          n_lin;
    int          n_b;
    int          base;

    rca_core i_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
        .prog_addr(prog_addr), .prog_data(prog_data), .acc_out(acc_out),
        .status_out(status_out), .branch_taken(branch_taken));
    rca_prog_rom i_rom (.clk(clk), .load_en(load_en),
        .load_addr(load_addr), .load_word(load_word),
        .rd_addr(prog_addr), .rd_data(prog_data));

    always #20 clk = ~clk;
    always @(posedge clk)
    begin
        if (rst_n && clk_en && branch_taken) n_br <= n_br + 1;
        if (acc_out === 8'hEE) saw_bad <= 1'b1;
    end

    task check(input string what, input logic [15:0] seen,
               input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // reset is held over the whole load, so fetch starts at word 0
    task load_prog(input logic [0:4][13:0] p);
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            rst_n     <= 1'b0;
            clk_en    <= 1'b1;
            load_en   <= 1'b1;
            load_addr <= 11'(i);
            load_word <= p[i];
        end
        @(posedge clk);
        load_en <= 1'b0;
        rst_n   <= 1'b1;
    endtask : load_prog

    task wait_acc(input logic [7:0] v, output int n);
        n = 0;
        while (acc_out !== v && n < 30)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check("acc reach", {8'h00, acc_out}, {8'h00, v});
    endtask : wait_acc

    task print_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    initial
    begin
        repeat (3000) @(posedge clk);
        failures++;
        $display("watchdog expired");
        print_verdict();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        #1;
        check("reset acc", {8'h00, acc_out}, 16'h0000);
        check("reset status", {8'h00, status_out}, 16'h0018);
        check("reset pc", {5'h00, prog_addr}, 16'h0000);
        $display("reset test done");
        foreach (rows[r])
        begin
            load_prog({rows[r].w, 14'h2804});
            repeat (12) @(posedge clk);
            #1;
            check("row acc", {8'h00, acc_out},
                  {8'h00, rows[r].acc});
            check("row status", {8'h00, status_out},
                  {8'h00, 5'h03, rows[r].fl});
        end
        $display("table test done");
        // one word per cycle, then a freeze in mid-stream
        load_prog({14'h3011, 14'h3022, 14'h3033, 14'h3044, 14'h2804});
        wait_acc(8'h11, n_lin);
        @(posedge clk);
        #1;
        check("next word", {8'h00, acc_out}, 16'h0022);
        @(posedge clk);
        clk_en <= 1'b0;
        #1;
        repeat (4) @(posedge clk);
        #1;
        check("frozen acc", {8'h00, acc_out}, 16'h0033);
        check("frozen pc", {5'h00, prog_addr}, 16'h0004);
        @(posedge clk);
        clk_en <= 1'b1;
        @(posedge clk);
        #1;
        check("resumed acc", {8'h00, acc_out}, 16'h0044);
        $display("pipeline test done");
        // prefetched words behind a jump must never execute
        load_prog({14'h2803, 14'h30EE, 14'h30EE, 14'h3055, 14'h2804});
        base = n_br;
        wait_acc(8'h55, n_b);
        check("branch cost", 16'(n_b - n_lin), 16'h0002);
        check("branch count", 16'(n_br - base), 16'h0001);
        check("discarded word", {15'h0000, saw_bad}, 16'h0000);
        $display("branch test done");
        load_prog({14'h2003, 14'h3066, 14'h2802, 14'h3055, 14'h0008});
        wait_acc(8'h55, n_b);
        wait_acc(8'h66, n_b);
        check("return cost", 16'(n_b), 16'h0003);
        $display("call test done");
        print_verdict();
    end
endmodule : rca_core_alu_datapath_bench
